// ### core/icycle_pkg.sv
// Purpose: Shared constants for the instruction-cycle register set.
// Assumes: 32-bit AXI4-Lite register access, bit 0 is the most significant bit in field naming.
// Notes:   Field positions are given in little-endian vector indices.
package icycle_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_KEY      = 8'h04;
  localparam logic [7:0] ADDR_BACKUP   = 8'h08;
  localparam logic [7:0] ADDR_IADDR    = 8'h0C;
  localparam logic [7:0] ADDR_OPADDR1  = 8'h10;
  localparam logic [7:0] ADDR_OPADDR2  = 8'h14;
  localparam logic [7:0] ADDR_PREFETCH = 8'h18;
  localparam logic [7:0] ADDR_CTRL     = 8'h1C;
  localparam logic [7:0] ADDR_STAT     = 8'h20;
  localparam logic [7:0] ADDR_GRBYTE   = 8'h24;
  // Status word field positions (little-endian indices).
  localparam int ILC_HI   = 31;
  localparam int ILC_LO   = 30;
  localparam int CC_HI    = 29;
  localparam int CC_LO    = 28;
  localparam int OP_HI    = 15;
  localparam int OP_LO    = 8;
  // Compare range: address bits 8-28 map to indices 23 downto 3.
  localparam int CMP_HI   = 23;
  localparam int CMP_LO   = 3;
  // Key register: bit 7 (index 0) reads zero.
  localparam logic [7:0] KEY_MASK  = 8'hFE;
  // Prefetch register: bit 31 (index 0) has no storage.
  localparam logic [31:0] PF_MASK  = 32'h00FF_FFFE;
  // Control register bits (write one to pulse).
  localparam int CTL_ENTER = 0;
  localparam int CTL_STORE = 1;
  localparam int CTL_UPDATE = 2;
  localparam int CTL_CLRREF = 3;
  localparam int CTL_EXEC  = 4;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// ### core/opcode_decode.sv
// Purpose: Instruction length code from the opcode.
// Assumes: Length code is taken from opcode bits 0-1.
// Notes:   Pure combinational decode.
`timescale 1ns/1ps
module opcode_decode (
  input  wire logic [7:0] opcode,
  output logic      [1:0] length_code
);
  // The two high opcode bits give 1, 2, 2 or 3 halfwords.
  always_comb begin
    case (opcode[7:6])
      2'b00:   length_code = 2'b01;
      2'b01:   length_code = 2'b10;
      2'b10:   length_code = 2'b10;
      default: length_code = 2'b11;
    endcase
  end
endmodule

// ### core/address_compare.sv
// Purpose: Doubleword compare of instruction and prefetch addresses against one operand address.
// Assumes: Addresses are 32-bit words with bit 8 at index 23.
// Notes:   Bits below the doubleword are ignored.
`timescale 1ns/1ps
module address_compare (
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] pref_addr,
  input  wire logic [31:0] oper_addr,
  output logic             hit
);
  // Either stream address hitting the operand marks a possible self-modify.
  always_comb begin
    hit = (instr_addr[icycle_pkg::CMP_HI:icycle_pkg::CMP_LO] == oper_addr[icycle_pkg::CMP_HI:icycle_pkg::CMP_LO]) ||
          (pref_addr[icycle_pkg::CMP_HI:icycle_pkg::CMP_LO] == oper_addr[icycle_pkg::CMP_HI:icycle_pkg::CMP_LO]);
  end
endmodule

// ### core/instruction_cycle_registers.sv
// Purpose: Instruction-cycle register set with AXI4-Lite access.
// Assumes: One clock, synchronous active-low reset, sequencer handshakes on the same clock.
// Notes:   Protected status fields ignore software writes.
// Overview of operation
// - Prefetch next doubleword while operands compute.
// - Hardware controls run beside microprogram.
// - Decode branch target from full opcode.
// - Opcode latch held through instruction cycle.
// - Opcode decode writes length code bits.
// - Execute modifier replaces byte when field nonzero.
// - Modifier loads general register byte three.
// - Immediate latch feeds status byte three.
// - Only hardware writes length code.
// - Condition code decides conditional branch.
// - Hardware sets opcode byte and immediate.
// - Status word mask, reserved, state bits.
// - Compare stream addresses at doubleword grain.
// - Store hit sets forced refetch latch.
// - Operand registers hold addresses bytes 1-3.
// - Key loads when instruction address written.
// - Key layout, bit seven reads zero.
// - Key substituted as byte zero on source.
// - Entry copies instruction address into backup.
// - Instruction address byte zero routes to key.
// - Prefetch bit 31 always zero.
// - Update loads low bits, high on carry.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module instruction_cycle_registers (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  fetch_opcode,
  input  wire logic [7:0]  fetch_imm_byte,
  input  wire logic        fetch_valid,
  input  wire logic        adder_carry29,
  input  wire logic [31:0] adder_sum,
  output logic [7:0]       branch_target,
  output logic             branch_taken,
  output logic             forced_refetch,
  output logic             prefetch_req
);
  // Register storage.
  logic [31:0] status_reg;
  logic [7:0]  key_reg;
  logic [31:0] backup_reg;
  logic [31:0] iaddr_reg;
  logic [31:0] opaddr1_reg;
  logic [31:0] opaddr2_reg;
  logic [31:0] prefetch_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  imm_reg;
  logic [7:0]  modifier_reg;
  logic [7:0]  grbyte_reg;
  logic        refetch_reg;
  logic [7:0]  target_reg;
  logic        taken_reg;
  logic        prefetch_req_reg;
  logic [1:0]  instr_length_code;
  logic        hit1;
  logic        hit2;
  // Bus handshake state.
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic        ctl_enter;
  logic        ctl_store;
  logic        ctl_update;
  logic        ctl_exec;
  logic        exec_pend_reg;
  logic [7:0]  imm_next;
  logic [31:0] status_wr, iaddr_wr, backup_wr, op1_wr, op2_wr;
  // Merge a byte-enabled write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // A write completes when both address and data have been taken.
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction
  opcode_decode u_decode (
    .opcode      (opcode_reg),
    .length_code (instr_length_code)
  );
  address_compare u_cmp1 (
    .instr_addr (iaddr_reg),
    .pref_addr  (prefetch_reg),
    .oper_addr  (opaddr1_reg),
    .hit        (hit1)
  );
  address_compare u_cmp2 (
    .instr_addr (iaddr_reg),
    .pref_addr  (prefetch_reg),
    .oper_addr  (opaddr2_reg),
    .hit        (hit2)
  );

  assign wr_fire    = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign ctl_enter  = wr_fire && hit_addr(aw_addr_reg, icycle_pkg::ADDR_CTRL) && w_data_reg[icycle_pkg::CTL_ENTER];
  assign ctl_store  = wr_fire && hit_addr(aw_addr_reg, icycle_pkg::ADDR_CTRL) && w_data_reg[icycle_pkg::CTL_STORE];
  assign ctl_update = wr_fire && hit_addr(aw_addr_reg, icycle_pkg::ADDR_CTRL) && w_data_reg[icycle_pkg::CTL_UPDATE];
  assign ctl_exec   = wr_fire && hit_addr(aw_addr_reg, icycle_pkg::ADDR_CTRL) && w_data_reg[icycle_pkg::CTL_EXEC];
  // Byte-merged write values, and the immediate byte that the next fetch will latch.
  assign status_wr = merge(status_reg, w_data_reg, w_strb_reg);
  assign iaddr_wr  = merge(iaddr_reg, w_data_reg, w_strb_reg);
  assign backup_wr = merge(backup_reg, w_data_reg, w_strb_reg);
  assign op1_wr    = merge(opaddr1_reg, w_data_reg, w_strb_reg);
  assign op2_wr    = merge(opaddr2_reg, w_data_reg, w_strb_reg);
  assign imm_next  = (exec_pend_reg && modifier_reg != 8'h00) ? modifier_reg : fetch_imm_byte;

  // Address and data channels are taken independently and held until the write retires.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= icycle_pkg::RESET_ZERO;
      w_strb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= icycle_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (aw_addr_reg <= icycle_pkg::ADDR_GRBYTE && aw_addr_reg[1:0] == 2'b00 &&
                     aw_addr_reg != icycle_pkg::ADDR_STAT) ? icycle_pkg::RESP_OKAY : icycle_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read path; the key is substituted as byte zero of every address register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= icycle_pkg::RESET_ZERO;
      rresp_reg  <= icycle_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= icycle_pkg::RESP_OKAY;
      case (s_axi_araddr)
        icycle_pkg::ADDR_STATUS:   rdata_reg <= status_reg;
        icycle_pkg::ADDR_KEY:      rdata_reg <= {24'h00_0000, key_reg};
        icycle_pkg::ADDR_BACKUP:   rdata_reg <= {key_reg, backup_reg[23:0]};
        icycle_pkg::ADDR_IADDR:    rdata_reg <= {key_reg, iaddr_reg[23:0]};
        icycle_pkg::ADDR_OPADDR1:  rdata_reg <= {key_reg, opaddr1_reg[23:0]};
        icycle_pkg::ADDR_OPADDR2:  rdata_reg <= {key_reg, opaddr2_reg[23:0]};
        icycle_pkg::ADDR_PREFETCH: rdata_reg <= {key_reg, prefetch_reg[23:0]};
        icycle_pkg::ADDR_CTRL:     rdata_reg <= icycle_pkg::RESET_ZERO;
        icycle_pkg::ADDR_STAT:     rdata_reg <= {16'h0000, modifier_reg, 6'h00, hit1 | hit2, refetch_reg};
        icycle_pkg::ADDR_GRBYTE:   rdata_reg <= {24'h00_0000, grbyte_reg};
        default: begin
          rdata_reg <= icycle_pkg::RESET_ZERO;
          rresp_reg <= icycle_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Opcode and immediate latches reload on a fetch; an execute arms the override for the next fetch.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opcode_reg    <= 8'h00;
      imm_reg       <= 8'h00;
      exec_pend_reg <= 1'b0;
    end else begin
      if (fetch_valid) begin
        opcode_reg <= fetch_opcode;
        imm_reg    <= imm_next;
      end
      if (ctl_exec) begin
        exec_pend_reg <= 1'b1;
      end else if (fetch_valid) begin
        exec_pend_reg <= 1'b0;
      end
    end
  end

  // Modifier takes byte 3 of the named general register when the first operand register is written.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      modifier_reg <= 8'h00;
      grbyte_reg   <= 8'h00;
    end else if (wr_fire) begin
      if (aw_addr_reg == icycle_pkg::ADDR_GRBYTE) begin
        grbyte_reg <= w_strb_reg[0] ? w_data_reg[7:0] : grbyte_reg;
      end
      if (aw_addr_reg == icycle_pkg::ADDR_OPADDR1) begin
        modifier_reg <= grbyte_reg;
      end
    end
  end

  // Status word: length code and opcode byte are hardware owned; software reaches the rest.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_reg <= icycle_pkg::RESET_ZERO;
    end else begin
      if (wr_fire && aw_addr_reg == icycle_pkg::ADDR_STATUS) begin
        status_reg[29:16] <= status_wr[29:16];
        status_reg[7:0]   <= status_wr[7:0];
      end
      status_reg[icycle_pkg::ILC_HI:icycle_pkg::ILC_LO] <= instr_length_code;
      status_reg[icycle_pkg::OP_HI:icycle_pkg::OP_LO]   <= opcode_reg;
      if (fetch_valid) begin
        status_reg[7:0] <= imm_next;
      end
    end
  end

  // Instruction address, key and backup; instruction address writes route byte zero into the key.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iaddr_reg  <= icycle_pkg::RESET_ZERO;
      key_reg    <= 8'h00;
      backup_reg <= icycle_pkg::RESET_ZERO;
    end else begin
      if (wr_fire && aw_addr_reg == icycle_pkg::ADDR_IADDR) begin
        iaddr_reg[23:0] <= iaddr_wr[23:0];
        if (w_strb_reg[3]) begin
          key_reg <= w_data_reg[31:24] & icycle_pkg::KEY_MASK;
        end
      end else if (ctl_update) begin
        iaddr_reg[2:0] <= prefetch_reg[2:0];
        if (adder_carry29) begin
          iaddr_reg[23:3] <= prefetch_reg[23:3];
        end
      end
      if (wr_fire && aw_addr_reg == icycle_pkg::ADDR_BACKUP) begin
        backup_reg[23:0] <= backup_wr[23:0];
      end else if (ctl_enter) begin
        backup_reg[23:0] <= iaddr_reg[23:0];
      end
    end
  end

  // Operand address registers and the prefetch address buffer.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opaddr1_reg  <= icycle_pkg::RESET_ZERO;
      opaddr2_reg  <= icycle_pkg::RESET_ZERO;
      prefetch_reg <= icycle_pkg::RESET_ZERO;
    end else begin
      if (wr_fire && aw_addr_reg == icycle_pkg::ADDR_OPADDR1) begin
        opaddr1_reg[23:0] <= op1_wr[23:0];
      end
      if (wr_fire && aw_addr_reg == icycle_pkg::ADDR_OPADDR2) begin
        opaddr2_reg[23:0] <= op2_wr[23:0];
      end
      // The adder runs every cycle so prefetch need not wait for the microprogram.
      prefetch_reg <= adder_sum & icycle_pkg::PF_MASK;
    end
  end

  // Forced refetch is set by a store hit; set wins over clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      refetch_reg <= 1'b0;
    end else if (ctl_store && (hit1 || hit2)) begin
      refetch_reg <= 1'b1;
    end else if (fetch_valid) begin
      refetch_reg <= 1'b0;
    end
  end

  // Sequencer-facing outputs: decode branch, condition branch and prefetch request.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      target_reg       <= 8'h00;
      taken_reg        <= 1'b0;
      prefetch_req_reg <= 1'b0;
    end else begin
      target_reg       <= opcode_reg;
      // Mask bit picked by condition code, immediate high nibble is the mask.
      taken_reg        <= imm_reg[3'd7 - {1'b0, status_reg[icycle_pkg::CC_HI:icycle_pkg::CC_LO]}];
      prefetch_req_reg <= !fetch_valid;
    end
  end

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign branch_target = target_reg;
  assign branch_taken  = taken_reg;
  assign forced_refetch = refetch_reg;
  assign prefetch_req  = prefetch_req_reg;

  a_refetch_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_store && (hit1 || hit2) |=> forced_refetch) else $error("Store hit did not set refetch.");
  a_length_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n && $stable(opcode_reg) |=> status_reg[31:30] == $past(instr_length_code)) else $error("Length code not from decode.");
  a_opcode_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> status_reg[15:8] == $past(opcode_reg)) else $error("Opcode byte not hardware set.");
  a_backup_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_enter |=> backup_reg[23:0] == $past(iaddr_reg[23:0])) else $error("Backup not loaded at entry.");
  a_key_bit7: assert property (@(posedge clk_sys) disable iff (!rst_n)
    key_reg[0] == 1'b0) else $error("Key bit 7 not zero.");
  a_pf_bit31: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prefetch_reg[0] == 1'b0 && prefetch_reg[31:24] == 8'h00) else $error("Prefetch bit 31 set.");
  a_update_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_update && !(wr_fire && aw_addr_reg == icycle_pkg::ADDR_IADDR) && !adder_carry29
    |=> iaddr_reg[23:3] == $past(iaddr_reg[23:3]) && iaddr_reg[2:0] == $past(prefetch_reg[2:0]))
    else $error("Update without carry changed high bits.");
  a_target_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> branch_target == $past(opcode_reg)) else $error("Branch target not opcode.");
  c_store_hit: cover property (@(posedge clk_sys) ctl_store && (hit1 || hit2));
  c_update_carry: cover property (@(posedge clk_sys) ctl_update && adder_carry29);
  c_exec_mod: cover property (@(posedge clk_sys) fetch_valid && exec_pend_reg && modifier_reg != 8'h00);
endmodule

// ### tb/fetch_model.sv
// Purpose: Far-side model of the storage fetch path feeding instruction bytes.
// Assumes: A request pulse on go starts one fetch; lag sets how slowly it answers.
// Notes:   While no fetch is pending the byte lines toggle so stale data never looks valid.
`timescale 1ns/1ps
module fetch_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] op,
  input  wire logic [7:0] imm,
  input  wire logic [3:0] lag,
  output logic      [7:0] fetch_opcode,
  output logic      [7:0] fetch_imm_byte,
  output logic            fetch_valid
);
  logic [3:0] cnt;
  logic       pend;

  // One valid pulse per request after lag cycles; idle lines are inverted each cycle.
  always_ff @(posedge clk_sys) begin
    fetch_valid <= 1'b0;
    if (!rst_n) begin
      pend           <= 1'b0;
      cnt            <= 4'h0;
      fetch_opcode   <= 8'h00;
      fetch_imm_byte <= 8'h00;
    end else if (go) begin
      pend <= 1'b1;
      cnt  <= lag;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend           <= 1'b0;
      fetch_valid    <= 1'b1;
      fetch_opcode   <= op;
      fetch_imm_byte <= imm;
    end else begin
      fetch_opcode   <= ~fetch_opcode;
      fetch_imm_byte <= ~fetch_imm_byte;
    end
  end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the instruction-cycle register set.
// Assumes: Registers are reached over AXI4-Lite; the adder is driven directly here.
// Notes:   Expected values come from the field layout, never from the design.
`timescale 1ns/1ps
`define OK icycle_pkg::RESP_OKAY
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic        clk_sys, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fvalid, carry, taken, refetch, go, preq;
  logic [7:0]  awaddr, araddr, fop, fimm, btgt, gop, gimm;
  logic [3:0]  wstrb, lag;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, sum, rd;
  logic [7:0]  ops [4] = '{8'h05, 8'h47, 8'h90, 8'hD2};
  logic [1:0]  instr_length_code [4] = '{2'b01, 2'b10, 2'b10, 2'b11};
  int          errors, comparisons;

  instruction_cycle_registers i_instruction_cycle_registers (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_opcode(fop),
    .fetch_imm_byte(fimm), .fetch_valid(fvalid), .adder_carry29(carry), .adder_sum(sum),
    .branch_target(btgt), .branch_taken(taken), .forced_refetch(refetch), .prefetch_req(preq));

  fetch_model i_fetch_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .go(go), .op(gop), .imm(gimm), .lag(lag),
    .fetch_opcode(fop), .fetch_imm_byte(fimm), .fetch_valid(fvalid));

  // Free-running 4 ns clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("counts: errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Write one word; both channels are offered together and released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    // Ready stays high between writes, so back-to-back calls never drive it twice in one step.
    if (n >= 100) errors++;
    `CHK(bresp, er)
  endtask

  // Read one word and compare the masked data and the response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rd = rdata;
    // Ready stays high between reads for the same reason as in the write task.
    if (n >= 100) errors++;
    `CHK(rd & m, e)
    `CHK(rresp, er)
  endtask

  // Ask the far side for one instruction and let the latches settle.
  task automatic fetch(input logic [7:0] o, input logic [7:0] m, input logic [3:0] l);
    int n;
    n = 0;
    gop  <= o;
    gimm <= m;
    lag  <= l;
    go   <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    while (!fvalid && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) errors++;
    // The request drops for the one cycle after the bytes were taken.
    #1;
    `CHK(preq, 1'b0)
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic done(input string name);
    $display("test %s finished, errors so far %0d", name, errors);
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most; the limit is 20000 cycles.
  initial begin
    #80000;
    errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, carry, go} = '0;
    {awaddr, araddr, gop, gimm, wstrb, lag, wdata, sum} = '0;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Opcode zero decodes to length code 01, and all-zero addresses already compare equal.
    for (int i = 0; i < 10; i++) rdc(8'(i * 4), (i == 0) ? 32'h4000_0000 : (i == 8) ? 32'h0000_0002 : 32'h0,
                                     32'hFFFF_FFFF, `OK);
    rdc(8'h28, 32'h0, 32'hFFFF_FFFF, icycle_pkg::RESP_SLVERR);
    wr(icycle_pkg::ADDR_STAT, 32'h1, 4'hF, icycle_pkg::RESP_SLVERR);
    `CHK(preq, 1'b1)
    done("reset");
    // Every length-code class, answered at different speeds.
    for (int i = 0; i < 4; i++) begin
      fetch(ops[i], ~ops[i], 4'(i * 3));
      rdc(icycle_pkg::ADDR_STATUS, {instr_length_code[i], 14'h0, ops[i], ~ops[i]}, 32'hFFFF_FFFF, `OK);
      `CHK(btgt, ops[i])
    end
    wr(icycle_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_STATUS, {2'b11, 6'h3F, 8'hFF, 8'hD2, 8'hFF}, 32'hFFFF_FFFF, `OK);
    wr(icycle_pkg::ADDR_STATUS, 32'h0, 4'hF, `OK);
    done("opcode");
    // Condition code picks one mask bit of the immediate byte.
    for (int c = 0; c < 4; c++) begin
      fetch(8'h47, 8'h80 >> c, 4'h1);
      wr(icycle_pkg::ADDR_STATUS, {2'b00, 2'(c), 28'h0}, 4'b1000, `OK);
      repeat (2) @(posedge clk_sys);
      `CHK(taken, 1'b1)
      fetch(8'h47, ~(8'h80 >> c), 4'h0);
      `CHK(taken, 1'b0)
    end
    done("branch");
    // The key has no write path of its own: it only follows byte zero of the instruction address.
    wr(icycle_pkg::ADDR_KEY, 32'hF1, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_KEY, 32'h00, 32'hFF, `OK);
    wr(icycle_pkg::ADDR_IADDR, 32'hFF12_3456, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_KEY, 32'hFE, 32'hFF, `OK);
    rdc(icycle_pkg::ADDR_IADDR, 32'hFE12_3456, 32'hFFFF_FFFF, `OK);
    wr(icycle_pkg::ADDR_CTRL, 32'h1, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_BACKUP, 32'hFE12_3456, 32'hFFFF_FFFF, `OK);
    // A retry brings the address back from the backup copy.
    wr(icycle_pkg::ADDR_IADDR, 32'hFE00_0040, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_BACKUP, 32'hFE12_3456, 32'hFFFF_FFFF, `OK);
    wr(icycle_pkg::ADDR_IADDR, rd, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_IADDR, 32'hFE12_3456, 32'hFFFF_FFFF, `OK);
    done("key and backup");
    sum <= 32'h0077_0000;
    wr(icycle_pkg::ADDR_GRBYTE, 32'h5A, 4'hF, `OK);
    wr(icycle_pkg::ADDR_OPADDR1, 32'h0012_3450, 4'hF, `OK);
    wr(icycle_pkg::ADDR_OPADDR2, 32'h0055_0000, 4'hF, `OK);
    wr(icycle_pkg::ADDR_CTRL, 32'h2, 4'hF, `OK);
    repeat (2) @(posedge clk_sys);
    `CHK(refetch, 1'b1)
    rdc(icycle_pkg::ADDR_STAT, 32'h5A03, 32'hFFFF, `OK);
    fetch(8'h47, 8'h00, 4'h2);
    `CHK(refetch, 1'b0)
    wr(icycle_pkg::ADDR_OPADDR1, 32'h0012_3460, 4'hF, `OK);
    wr(icycle_pkg::ADDR_CTRL, 32'h2, 4'hF, `OK);
    repeat (2) @(posedge clk_sys);
    `CHK(refetch, 1'b0)
    wr(icycle_pkg::ADDR_OPADDR2, 32'h0077_0004, 4'hF, `OK);
    wr(icycle_pkg::ADDR_CTRL, 32'h2, 4'hF, `OK);
    repeat (2) @(posedge clk_sys);
    `CHK(refetch, 1'b1)
    fetch(8'h47, 8'h00, 4'h0);
    done("compare");
    sum <= 32'hAB77_0003;
    repeat (2) @(posedge clk_sys);
    rdc(icycle_pkg::ADDR_PREFETCH, 32'h0077_0002, 32'h00FF_FFFF, `OK);
    // Low bits always follow the adder; the doubleword bits only on carry.
    wr(icycle_pkg::ADDR_IADDR, 32'hFE12_3456, 4'hF, `OK);
    sum <= 32'h0012_345D;
    wr(icycle_pkg::ADDR_CTRL, 32'h4, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_IADDR, 32'hFE12_3454, 32'hFFFF_FFFF, `OK);
    sum   <= 32'h0012_3461;
    carry <= 1'b1;
    wr(icycle_pkg::ADDR_CTRL, 32'h4, 4'hF, `OK);
    rdc(icycle_pkg::ADDR_IADDR, 32'hFE12_3460, 32'hFFFF_FFFF, `OK);
    done("update");
    // Execute with a zero and then a nonzero modifier.
    for (int k = 0; k < 2; k++) begin
      wr(icycle_pkg::ADDR_GRBYTE, k ? 32'h5A : 32'h0, 4'hF, `OK);
      wr(icycle_pkg::ADDR_OPADDR1, 32'h0, 4'hF, `OK);
      wr(icycle_pkg::ADDR_CTRL, 32'h10, 4'hF, `OK);
      fetch(8'h44, 8'h11, 4'h1);
      rdc(icycle_pkg::ADDR_STATUS, k ? 32'h5A : 32'h11, 32'hFF, `OK);
    end
    done("execute");
    give_verdict();
  end
endmodule
